// ---- pcf_fetch_pipeline.sv ----
// program counter and four-phase instruction fetch sequencer with wishbone access
// Contract
// RL1 - four phases from system clock form one cycle
// RL2 - counter advances and fetch starts at first phase
// RL3 - next fetch overlaps current execution; extended takes two
// RL4 - counter-changing instructions cost one extra cycle
// RL5 - counter otherwise increases by exactly one
// RL6 - jump, call, interrupt, reset load destination directly
// RL7 - satisfied skip discards prefetch, runs dummy cycle
// RL8 - counter 12 or 13 bits, low byte visible
// RL9 - low byte writable, branch stays in page
// RL10 - low byte write inserts one dummy cycle
// RL11 - reset loads vector zero, execution starts there
// RL12 - low byte write keeps upper counter bits
`timescale 1ns/100ps
`default_nettype none
module pcf_fetch_pipeline
    import pcf_pkg::*;
#(
    parameter int PC_W = PCF_PC_W_DEF // RL8 width, 12 or 13
) (
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    // wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [3:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    // program memory side
    output logic [PC_W-1:0] PMEM_ADDR_OUT,
    output logic PMEM_RD_OUT,
    input wire logic [PCF_INSTR_W-1:0] PMEM_DATA_IN,
    // decode and execute side
    output logic [3:0] PHASE_OUT,
    output logic [PCF_INSTR_W-1:0] INSTR_OUT,
    output logic INSTR_VALID_OUT,
    output logic INSTR_SECOND_OUT,
    output logic [PC_W-1:0] PC_OUT,
    input wire logic BRANCH_IN,
    input wire logic [PC_W-1:0] TARGET_IN,
    input wire logic SKIP_IN,
    input wire logic EXTEND_IN
);
    // phase sequencer state
    pcf_phase_e phase_r, phase_nxt;
    logic [3:0] phase_oh_r, phase_oh_nxt;       // one-hot copy for the decoder
    // counter and fetch state
    logic [PC_W-1:0] pc_r, pc_nxt;               // next address to fetch
    logic [PC_W-1:0] faddr_r, faddr_nxt;         // address of the word in flight
    logic rd_r, rd_nxt;                          // memory read strobe
    logic hold_r, hold_nxt;                      // no fetch in extended second cycle
    logic [PCF_INSTR_W-1:0] fetch_r, fetch_nxt;  // prefetched word
    logic [PCF_INSTR_W-1:0] instr_r, instr_nxt;  // word under execution
    logic valid_r, valid_nxt;                    // low marks a dummy cycle
    logic second_r, second_nxt;                  // second cycle of an extended word
    logic boot_r, boot_nxt;                      // first cycle after reset
    // bus state
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic pend_r, pend_nxt;                      // low byte write awaiting cycle end
    logic [PCF_PCL_W-1:0] pdat_r, pdat_nxt;      // value written to the low byte
    // decode helpers
    logic cyc_end;                               // last phase of the cycle
    logic redirect;                              // prefetched word must be dropped
    logic [PC_W-1:0] pc_src;                     // address fetched next cycle
    logic bus_req;
    logic pcl_wr;
    logic [31:0] stat_word;

    assign cyc_end = (phase_r == PCF_T4);
    assign bus_req = WB_CYC_IN && WB_STB_IN && !ack_r;
    assign pcl_wr = bus_req && WB_WE_IN && (WB_ADR_IN == PCF_OFS_PCL) && WB_SEL_IN[0];

    // redirect target, priority reset then branch then low byte write then skip
    always_comb begin
        redirect = 1'b0;
        pc_src = pc_r;
        if (boot_r) begin
            redirect = 1'b1;
            pc_src = PCF_RESET_VECTOR[PC_W-1:0]; // RL11
        end else if (valid_r && BRANCH_IN) begin
            redirect = 1'b1;
            pc_src = TARGET_IN; // RL6
        end else if (pend_r) begin
            redirect = 1'b1;
            // only the low byte changes so the jump stays in page
            pc_src = {pc_r[PC_W-1:PCF_PCL_W], pdat_r}; // RL9 RL12
        end else if (valid_r && SKIP_IN && !second_r) begin
            redirect = 1'b1; // RL7
        end
    end

    // phase rotation, one state per clock, no stall ever
    always_comb begin
        case (phase_r)
            PCF_T1: phase_nxt = PCF_T2;
            PCF_T2: phase_nxt = PCF_T3;
            PCF_T3: phase_nxt = PCF_T4;
            PCF_T4: phase_nxt = PCF_T1;
            default: phase_nxt = PCF_T1;
        endcase
        phase_oh_nxt = 4'h1 << phase_nxt; // RL1
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            phase_r <= PCF_PHASE_RST;
            phase_oh_r <= PCF_PHASE_OH_RST;
        end else begin
            phase_r <= phase_nxt;
            phase_oh_r <= phase_oh_nxt;
        end
    end

    // counter, fetch address and execute slot updated at the end of the last phase, prefetched word at the end of the second
    always_comb begin
        pc_nxt = pc_r;
        faddr_nxt = faddr_r;
        rd_nxt = 1'b0;
        hold_nxt = hold_r;
        fetch_nxt = fetch_r;
        instr_nxt = instr_r;
        valid_nxt = valid_r;
        second_nxt = second_r;
        boot_nxt = boot_r;
        // word read during the first phase is returned in the second
        if (phase_r == PCF_T2 && !hold_r) begin
            fetch_nxt = PMEM_DATA_IN; // RL3
        end
        if (cyc_end) begin
            boot_nxt = 1'b0;
            if (redirect) begin
                // dropping the prefetch costs exactly one dummy cycle
                instr_nxt = PCF_DUMMY_WORD; // RL4 RL7 RL10
                valid_nxt = 1'b0;
                second_nxt = 1'b0;
                hold_nxt = 1'b0;
                faddr_nxt = pc_src; // RL2
                pc_nxt = pc_src + 1'b1; // RL5
                rd_nxt = 1'b1;
            end else if (valid_r && EXTEND_IN && !second_r) begin
                // extended word keeps the slot, prefetch waits one cycle
                second_nxt = 1'b1; // RL3
                hold_nxt = 1'b1;
            end else begin
                instr_nxt = fetch_r; // RL3
                valid_nxt = 1'b1;
                second_nxt = 1'b0;
                hold_nxt = 1'b0;
                faddr_nxt = pc_r; // RL2
                pc_nxt = pc_r + 1'b1; // RL5
                rd_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            pc_r <= '0;
            faddr_r <= '0;
            rd_r <= 1'b0;
            hold_r <= 1'b0;
            fetch_r <= PCF_DUMMY_WORD;
            instr_r <= PCF_DUMMY_WORD;
            valid_r <= 1'b0;
            second_r <= 1'b0;
            boot_r <= 1'b1;
        end else begin
            pc_r <= pc_nxt;
            faddr_r <= faddr_nxt;
            rd_r <= rd_nxt;
            hold_r <= hold_nxt;
            fetch_r <= fetch_nxt;
            instr_r <= instr_nxt;
            valid_r <= valid_nxt;
            second_r <= second_nxt;
            boot_r <= boot_nxt;
        end
    end

    // status word: live counter, slot flags and phase
    always_comb begin
        stat_word = '0;
        stat_word[PCF_STAT_PC_LSB +: PC_W] = pc_r;
        stat_word[PCF_STAT_VALID_BIT] = valid_r;
        stat_word[PCF_STAT_SECOND_BIT] = second_r;
        stat_word[PCF_STAT_PEND_BIT] = pend_r;
        stat_word[PCF_STAT_PHASE_LSB +: 2] = phase_r;
    end

    // wishbone slave, one wait state, unmapped reads return zero
    always_comb begin
        ack_nxt = bus_req;
        rdat_nxt = rdat_r;
        pend_nxt = pend_r;
        pdat_nxt = pdat_r;
        if (bus_req && !WB_WE_IN) begin
            case (WB_ADR_IN)
                PCF_OFS_PCL: rdat_nxt = {24'h000000, pc_r[PCF_PCL_W-1:0]}; // RL8
                PCF_OFS_STAT: rdat_nxt = stat_word;
                default: rdat_nxt = PCF_WB_DAT_RST;
            endcase
        end
        // applied at the coming cycle end, or dropped if a branch is taken there; a new write in that cycle wins
        if (cyc_end && pend_r && !boot_r) begin
            pend_nxt = 1'b0;
        end
        if (pcl_wr) begin
            pend_nxt = 1'b1; // RL9
            pdat_nxt = WB_DAT_IN[PCF_PCL_W-1:0];
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ack_r <= 1'b0;
            rdat_r <= PCF_WB_DAT_RST;
            pend_r <= 1'b0;
            pdat_r <= '0;
        end else begin
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
            pend_r <= pend_nxt;
            pdat_r <= pdat_nxt;
        end
    end

    assign WB_ACK_OUT = ack_r;
    assign WB_DAT_OUT = rdat_r;
    assign PMEM_ADDR_OUT = faddr_r;
    assign PMEM_RD_OUT = rd_r;
    assign PHASE_OUT = phase_oh_r;
    assign INSTR_OUT = instr_r;
    assign INSTR_VALID_OUT = valid_r;
    assign INSTR_SECOND_OUT = second_r;
    assign PC_OUT = pc_r;

    // checks on the sequencer
    // the assertions below watch internal state as well as ports, so they
    // follow the registers and not the outputs that merely copy them, except a_bus_ack, which reads WB_ACK_OUT
    // all of them are off while reset is held; the async reset would otherwise
    // let $past and $stable see values from before the reset edge
    // the phase checks assume no stall, so a future wait state in the
    // sequencer must relax a_phase_rotate and a_pc_hold together
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);

    a_phase_rotate: assert property (phase_r == PCF_T4 |=> phase_r == PCF_T1 ##1 phase_r == PCF_T2 ##1 phase_r == PCF_T3 ##1 phase_r == PCF_T4) else $error("phase order broken"); // RL1
    a_phase_onehot: assert property ($onehot(phase_oh_r) && phase_oh_r[phase_r]) else $error("phase outputs wrong"); // RL1
    a_read_first: assert property (rd_r |-> phase_r == PCF_T1 && pc_r == faddr_r + 1'b1) else $error("read not at first phase"); // RL2
    a_pc_hold: assert property (phase_r != PCF_T4 |=> $stable(pc_r)) else $error("counter moved mid cycle"); // RL5
    a_seq_step: assert property (cyc_end && !redirect && !(valid_r && EXTEND_IN && !second_r) |=> pc_r == $past(pc_r) + 1'b1 && valid_r && instr_r == $past(fetch_r)) else $error("sequential step wrong"); // RL5
    a_branch_load: assert property (cyc_end && !boot_r && valid_r && BRANCH_IN |=> faddr_r == $past(TARGET_IN) && !valid_r ##4 valid_r) else $error("branch not loaded"); // RL4
    a_skip_dummy: assert property (cyc_end && !boot_r && valid_r && !BRANCH_IN && !pend_r && SKIP_IN && !second_r |=> !valid_r && faddr_r == $past(pc_r)) else $error("skip did not drop prefetch"); // RL7
    a_extend_two: assert property (cyc_end && !redirect && valid_r && EXTEND_IN && !second_r |=> second_r && !rd_r && $stable(instr_r) ##3 cyc_end) else $error("extended cycle wrong"); // RL3
    a_pcl_page: assert property (cyc_end && pend_r && !boot_r && !(valid_r && BRANCH_IN) |=> faddr_r[PC_W-1:PCF_PCL_W] == $past(pc_r[PC_W-1:PCF_PCL_W]) && faddr_r[PCF_PCL_W-1:0] == $past(pdat_r) && !valid_r) else $error("low byte jump wrong"); // RL9

    // a low byte write is latched at once and held until the next cycle end, which applies it unless a branch is taken
    a_pcl_pend: assert property (pcl_wr |=> pend_r) else $error("low byte write lost"); // RL10
    // away from a cycle end nothing may clear the pending write
    a_pend_hold: assert property (pend_r && !cyc_end |=> pend_r) else $error("pending write dropped"); // RL10
    // the cycle end that applies the write also clears it, unless a new write lands
    a_pend_clear: assert property (cyc_end && pend_r && !boot_r && !pcl_wr |=> !pend_r) else $error("pending write not cleared"); // RL10

    // a dummy slot always carries the dummy word, never a stale prefetch
    a_dummy_word: assert property (!valid_r |-> instr_r == PCF_DUMMY_WORD) else $error("dummy slot not empty"); // RL7

    // the memory strobe is a single clock pulse
    a_rd_pulse: assert property (rd_r |=> !rd_r) else $error("read strobe too long"); // RL2

    // the fetch address stands for the whole instruction cycle
    a_addr_stable: assert property (!cyc_end |=> $stable(faddr_r)) else $error("fetch address moved"); // RL2

    // the executing word may only change at a cycle end
    a_instr_stable: assert property (!cyc_end |=> $stable(instr_r)) else $error("instruction moved"); // RL3
    a_reset_vec: assert property (boot_r && cyc_end |=> faddr_r == '0 && rd_r) else $error("reset vector not used"); // RL11
    a_bus_ack: assert property (bus_req |=> WB_ACK_OUT ##1 !WB_ACK_OUT) else $error("bus ack timing wrong");

    c_branch: cover property (cyc_end && valid_r && BRANCH_IN);
    c_skip: cover property (cyc_end && valid_r && SKIP_IN && !BRANCH_IN);
    c_extend: cover property (second_r && cyc_end);
    c_pcl_write: cover property (pcl_wr ##[1:8] (cyc_end && pend_r));
    // restart from the vector, seen again after a mid-run reset
    c_boot: cover property (boot_r && cyc_end);
endmodule
`default_nettype wire

// ---- pcf_pkg.sv ----
// constants shared by the program counter and fetch sequencer
package pcf_pkg;
    // instruction phases, one full sequence is one instruction cycle
    typedef enum logic [1:0] {
        PCF_T1 = 2'b00,
        PCF_T2 = 2'b01,
        PCF_T3 = 2'b10,
        PCF_T4 = 2'b11
    } pcf_phase_e;
    localparam pcf_phase_e PCF_PHASE_RST = PCF_T4; // reset parks at the last phase
    localparam int PCF_PC_W_DEF = 12;              // 12 or 13 bits by memory size
    localparam int PCF_INSTR_W = 16;               // program word width
    localparam int PCF_PCL_W = 8;                  // software visible low byte
    // register byte offsets on the bus
    localparam logic [3:0] PCF_OFS_PCL = 4'h0;     // program_counter_low
    localparam logic [3:0] PCF_OFS_STAT = 4'h4;    // status and full counter
    // status field positions
    localparam int PCF_STAT_PC_LSB = 0;
    localparam int PCF_STAT_VALID_BIT = 16;
    localparam int PCF_STAT_SECOND_BIT = 17;
    localparam int PCF_STAT_PEND_BIT = 18;
    localparam int PCF_STAT_PHASE_LSB = 20;
    // reset values
    localparam logic [15:0] PCF_RESET_VECTOR = 16'h0000;
    localparam logic [15:0] PCF_DUMMY_WORD = 16'h0000;
    localparam logic [3:0] PCF_PHASE_OH_RST = 4'h8;
    localparam logic [31:0] PCF_WB_DAT_RST = 32'h0000_0000;
endpackage

// ---- pcf_pmem_model.sv ----
// program memory model answering fetch strobes one clock later
`timescale 1ns/100ps
`default_nettype none
module pcf_pmem_model
    import pcf_pkg::*;
#(
    parameter int PC_W = PCF_PC_W_DEF // fetch address width
) (
    input wire logic clock_in,
    input wire logic [PC_W-1:0] addr_in,
    input wire logic rd_in,
    output logic [PCF_INSTR_W-1:0] data_out
);
    // word at address a is 5000h ORed with a, so every fetch is traceable
    // outside the valid slot the word flips each clock, never holds stale data
    always_ff @(posedge clock_in) begin
        if (rd_in) begin
            data_out <= 16'h5000 | 16'(addr_in);
        end else begin
            data_out <= ~data_out;
        end
    end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking testbench for the program counter and fetch sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top import pcf_pkg::*; ;
    localparam int W = PCF_PC_W_DEF;
    typedef struct packed {logic b; logic [W-1:0] tg; logic s; logic e; logic p; logic [7:0] d;
        logic v;} pcf_row_s;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, br = 0, sk = 0, ex = 0;
    logic [3:0] adr = 4'h0, sel = 4'h0, ph;
    logic [31:0] wdat = 32'h0, rdat, rd_v;
    logic ack, prd, val, sec, val_e, sec_e;
    logic [W-1:0] pa, pc, tgt = '0, pc_e, pre_e, t;
    logic [15:0] md, ins, ins_e;
    int bad_count = 0, num_checks = 0;
    // decisions: branch, target, skip, extend, low byte write, byte, valid after
    pcf_row_s rows [12] = '{'{0, 12'h0, 0, 0, 0, 8'h0, 1}, '{0, 12'h0, 0, 1, 0, 8'h0, 1},
        '{0, 12'h0, 1, 0, 0, 8'h0, 1}, '{1, 12'h3f0, 0, 0, 0, 8'h0, 0},
        '{1, 12'h100, 0, 0, 0, 8'h0, 1}, '{0, 12'h0, 1, 0, 0, 8'h0, 0},
        '{0, 12'h0, 0, 0, 0, 8'h0, 1}, '{0, 12'h0, 0, 0, 1, 8'hfe, 0},
        '{0, 12'h0, 0, 0, 0, 8'h0, 1}, '{0, 12'h0, 0, 0, 0, 8'h0, 1},
        '{1, 12'hfff, 0, 0, 0, 8'h0, 0}, '{0, 12'h0, 0, 0, 0, 8'h0, 1}};
    pcf_fetch_pipeline #(.PC_W(W)) uut (.CLOCK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .PMEM_ADDR_OUT(pa), .PMEM_RD_OUT(prd),
        .PMEM_DATA_IN(md), .PHASE_OUT(ph), .INSTR_OUT(ins), .INSTR_VALID_OUT(val),
        .INSTR_SECOND_OUT(sec), .PC_OUT(pc), .BRANCH_IN(br), .TARGET_IN(tgt), .SKIP_IN(sk),
        .EXTEND_IN(ex));
    pcf_pmem_model #(.PC_W(W)) mem (.clock_in(clk), .addr_in(pa), .rd_in(prd), .data_out(md));
    // free-running 20 mhz clock
    initial begin
        forever #25 clk = ~clk;
    end
    // one shared compare keeps every check identical in form
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // classic single wishbone cycle, held until ack is sampled high
    task wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n == 20) chk(32'h0, 32'h1, "ack timeout");
        rd_v = rdat;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask
    // reset held n+1 clocks, then the first fetch slot starts at address zero
    task do_reset(input int n);
        @(posedge clk);
        rst <= 1;
        repeat (n) @(posedge clk);
        #1;
        chk({ph, pc, 1'b0, prd, val, ack}, {4'h8, 12'h0, 4'h0}, "in reset");
        @(posedge clk);
        rst <= 0;
        @(posedge clk);
        #1;
        chk({ph, pa, pc, prd, val}, {4'h1, 12'h0, 12'h1, 2'b10}, "after reset");
        pc_e = 1;
        pre_e = 0;
        val_e = 0;
        sec_e = 0;
        @(posedge clk);
        #1;
        chk(32'(ph), 32'h2, "phase two");
        @(posedge clk);
        #1;
        chk(32'(ph), 32'h4, "phase three");
    endtask
    // one instruction-cycle decision at the end of the fourth phase
    task slot(input pcf_row_s r);
        int n;
        n = 0;
        if (r.p) wb(1'b1, PCF_OFS_PCL, 4'h1, {24'h0, r.d});
        else begin
            @(posedge clk);
            while (ph !== 4'h4 && n < 20) begin
                n++;
                @(posedge clk);
            end
            br <= r.b;
            tgt <= r.tg;
            sk <= r.s;
            ex <= r.e;
        end
        @(posedge clk);
        br <= 0;
        sk <= 0;
        ex <= 0;
        if (r.b && val_e) begin
            pre_e = r.tg;
            pc_e = r.tg + 1'b1;
            val_e = 0;
        end else if (r.p) begin
            t = {pc_e[W-1:8], r.d};
            pre_e = t;
            pc_e = t + 1'b1;
            val_e = 0;
        end else if (r.s && val_e && !sec_e) begin
            pre_e = pc_e;
            pc_e = pc_e + 1'b1;
            val_e = 0;
        end else if (r.e && val_e && !sec_e) sec_e = 1;
        else begin
            ins_e = 16'h5000 | 16'(pre_e);
            pre_e = pc_e;
            pc_e = pc_e + 1'b1;
            val_e = 1;
            sec_e = 0;
        end
        #1;
        chk(32'(ph), 32'h1, "phase one");
        chk(32'(pa), 32'(pre_e), "fetch address");
        chk(32'(pc), 32'(pc_e), "counter");
        chk({val, sec, prd}, {r.v, sec_e, !sec_e}, "slot kind");
        if (val_e) chk(32'(ins), 32'(ins_e), "instruction");
    endtask
    initial begin
        #(5000 * 50);
        chk(32'h0, 32'h1, "watchdog");
        stop_test;
    end
    initial begin
        do_reset(9);
        for (int i = 0; i < 12; i++) slot(rows[i]);
        $display("decision table done");
        wb(1'b0, PCF_OFS_PCL, 4'hf, 32'h0);
        chk(rd_v, {24'h0, pc_e[7:0]}, "low byte read");
        wb(1'b1, PCF_OFS_PCL, 4'he, 32'h55);
        wb(1'b0, PCF_OFS_STAT, 4'hf, 32'h0);
        chk({rd_v[31:22], rd_v[18]}, 11'h0, "masked write");
        wb(1'b0, 4'h8, 4'hf, 32'h0);
        chk(rd_v, 32'h0, "unmapped read");
        $display("register tests done");
        do_reset(2);
        slot(rows[0]);
        $display("second reset done");
        stop_test;
    end
endmodule
`default_nettype wire
